// ---- asf_pkg.sv ----
// Package: constants and carriers for the security and set-features command block
package asf_pkg;
	// ------------------------------------------------------------
	// Command and subcommand codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_SET_PW   = 8'hF1;
	localparam logic [7:0] CMD_UNLOCK   = 8'hF2;
	localparam logic [7:0] CMD_ERASE    = 8'hF4;
	localparam logic [7:0] CMD_SETFEAT  = 8'hEF;
	localparam logic [7:0] SF_8BIT_EN   = 8'h01;
	localparam logic [7:0] SF_8BIT_DIS  = 8'h81;
	localparam logic [7:0] SF_WC_EN     = 8'h02;
	localparam logic [7:0] SF_WC_DIS    = 8'h82;
	localparam logic [7:0] SF_XFER      = 8'h03;
	localparam logic [7:0] SF_APM_EN    = 8'h05;
	localparam logic [7:0] SF_APM_DIS   = 8'h85;
	localparam logic [7:0] SF_EXT_EN    = 8'h09;
	localparam logic [7:0] SF_EXT_DIS   = 8'h89;
	localparam logic [7:0] SF_PL1_EN    = 8'h0A;
	localparam logic [7:0] SF_PL1_DIS   = 8'h8A;
	localparam logic [7:0] SF_RLA_DIS   = 8'h55;
	localparam logic [7:0] SF_RLA_EN    = 8'hAA;
	localparam logic [7:0] SF_POR_DIS   = 8'h66;
	localparam logic [7:0] SF_POR_EN    = 8'hCC;
	localparam logic [7:0] SF_NOP_A     = 8'h69;
	localparam logic [7:0] SF_NOP_B     = 8'h96;
	localparam logic [7:0] SF_NOP_C     = 8'h97;
	localparam logic [7:0] SF_CUR_LIM   = 8'h9A;
	localparam logic [7:0] SF_LONG4     = 8'hBB;
	// ------------------------------------------------------------
	// Transfer type codes, sector layout, limits
	// ------------------------------------------------------------
	localparam logic [4:0] XT_PIO_DEF   = 5'h00;
	localparam logic [4:0] XT_PIO_FC    = 5'h01;
	localparam logic [4:0] XT_MDMA      = 5'h04;
	localparam logic [4:0] XT_UDMA      = 5'h08;
	localparam logic [2:0] XM_NO_IORDY  = 3'h1;
	localparam logic [2:0] PIO_IORDY_MIN = 3'h3;
	localparam int         CW_ID_BIT    = 0;
	localparam int         CW_LVL_BIT   = 8;
	localparam logic [7:0] PW_FIRST     = 8'h01;
	localparam logic [7:0] PW_LAST      = 8'h10;
	localparam logic [7:0] SECT_LAST    = 8'hFF;
	localparam logic [2:0] UNLOCK_TRIES = 3'h5;
	localparam logic [7:0] APM_MIN      = 8'h01;
	localparam logic [7:0] APM_MAX      = 8'hFE;
	localparam logic [7:0] STAT_DRDY    = 8'h40;
	localparam logic [7:0] STAT_ERR     = 8'h01;
	localparam logic [7:0] ERR_ABRT     = 8'h04;
	// ------------------------------------------------------------
	// Register map (word offsets) and fields
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CFG      = 4'h0;
	localparam logic [3:0] REG_SEC      = 4'h1;
	localparam logic [3:0] REG_FEAT     = 4'h2;
	localparam logic [3:0] REG_MODE     = 4'h3;
	localparam int         CFG_NOIORDY  = 0;
	localparam int         CFG_NVCLR    = 1;

	typedef enum logic [1:0] {ASF_DMA_NONE, ASF_DMA_MW, ASF_DMA_UL} asf_dma_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] feat;
		logic [7:0] scnt;
	} asf_cmd_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
	} asf_res_t;
endpackage : asf_pkg

// ---- asf_core.sv ----
// Module: security password and set-features command interpreter
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The address-and-strobe port and the address map are this design's own decisions.
module asf_core
	import asf_pkg::*;
#(
	parameter logic [2:0] PIO_MAX  = 3'h4,
	parameter logic [2:0] MDMA_MAX = 3'h2,
	parameter logic [2:0] UDMA_MAX = 3'h6,
	parameter logic [7:0] CUR_MIN  = 8'h01,
	parameter logic [7:0] CUR_MAX  = 8'h7D,
	parameter logic       WC_DEF   = 1'b1
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              soft_rst,
	// Task file command
	input  wire logic              cmd_valid,
	input  wire asf_pkg::asf_cmd_t cmd,
	output logic                   cmd_ready,
	// Data sector words
	input  wire logic              dw_valid,
	input  wire logic [15:0]       dw_data,
	output logic                   dw_ready,
	// Completion
	output logic                   done,
	output asf_pkg::asf_res_t      res,
	// Cache flush handshake
	output logic                   flush_req,
	input  wire logic              flush_ack,
	// Data path indicators
	input  wire logic              data_reg_acc,
	output logic                   sixteen_bit_io_indicator,
	output logic                   low_lanes_only,
	output logic                   iordy_en,
	output logic                   look_ahead_en,
	output logic                   wcache_en,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata
);
	import asf_pkg::*;

	typedef enum logic [1:0] {ASF_IDLE, ASF_DATA, ASF_FLUSH} asf_st_t;

	asf_st_t        st_q;
	logic [7:0]     code_q;
	logic [7:0]     widx_q;
	logic           id_master_q;
	logic           lvl_new_q;
	logic           miss_q;
	logic [15:0]    user_pw [16];
	logic [15:0]    master_pw [16];
	logic           sec_en_q;
	logic           lvl_max_q;
	logic           locked_q;
	logic [2:0]     tries_q;
	logic           eight_q;
	logic           wc_q;
	logic           rla_q;
	logic           por_srst_q;
	logic           apm_en_q;
	logic [7:0]     apm_lvl_q;
	logic [7:0]     cur_q;
	logic [2:0]     pio_q;
	logic           no_iordy_q;
	asf_dma_t       dma_q;
	logic [2:0]     dma_mode_q;
	logic           cfg_noiordy_q;
	logic           take;
	logic           word;
	logic           last;
	logic           sf_bad;
	logic           ul_end;
	logic           ul_bad;
	logic           ul_dec;
	logic [3:0]     pw_i;
	logic [15:0]    pw_ref;
	logic           nv_clr;
	logic [4:0]     xtype;
	logic [2:0]     xmode;

	assign take     = cmd_valid && cmd_ready;
	assign word     = dw_valid && dw_ready;
	assign last     = word && (widx_q == SECT_LAST);
	assign pw_i     = 4'(widx_q - PW_FIRST);
	assign xtype    = cmd.scnt[7:3];
	assign xmode    = cmd.scnt[2:0];
	assign nv_clr   = reg_wr && (reg_addr == REG_CFG) && reg_wdata[CFG_NVCLR];

	// ------------------------------------------------------------
	// Handshakes and indicators
	// ------------------------------------------------------------
	assign cmd_ready = (st_q == ASF_IDLE);
	assign dw_ready  = (st_q == ASF_DATA);
	assign flush_req = (st_q == ASF_FLUSH);
	assign sixteen_bit_io_indicator = data_reg_acc && !eight_q;
	assign low_lanes_only = eight_q;
	assign iordy_en  = !no_iordy_q || (pio_q >= PIO_IORDY_MIN);
	assign look_ahead_en = rla_q;
	assign wcache_en = wc_q;

	// ------------------------------------------------------------
	// Set-features subcommand validity
	// ------------------------------------------------------------
	always_comb begin
		sf_bad = 1'b0;
		case (cmd.feat)
			SF_8BIT_EN, SF_8BIT_DIS, SF_WC_EN, SF_WC_DIS, SF_APM_DIS,
			SF_EXT_EN, SF_EXT_DIS, SF_PL1_EN, SF_PL1_DIS, SF_RLA_DIS,
			SF_RLA_EN, SF_POR_DIS, SF_POR_EN, SF_NOP_A, SF_NOP_B,
			SF_NOP_C, SF_CUR_LIM, SF_LONG4: sf_bad = 1'b0;
			SF_APM_EN: sf_bad = (cmd.scnt < APM_MIN) || (cmd.scnt > APM_MAX);
			SF_XFER: begin
				case (xtype)
					XT_PIO_DEF: sf_bad = (xmode > XM_NO_IORDY) ||
						((xmode == XM_NO_IORDY) && !cfg_noiordy_q);
					XT_PIO_FC: sf_bad = (xmode > PIO_MAX);
					XT_MDMA:   sf_bad = (xmode > MDMA_MAX);
					XT_UDMA:   sf_bad = (xmode > UDMA_MAX);
					default:   sf_bad = 1'b1;
				endcase
			end
			default: sf_bad = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// Unlock evaluation at end of sector
	// ------------------------------------------------------------
	assign pw_ref = id_master_q ? master_pw[pw_i] : user_pw[pw_i];
	assign ul_end = last && (code_q == CMD_UNLOCK);
	assign ul_bad = ul_end && locked_q && ((id_master_q && lvl_max_q) || miss_q);
	assign ul_dec = ul_bad && !(id_master_q && lvl_max_q);

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q   <= ASF_IDLE;
			code_q <= 8'h00;
		end else begin
			case (st_q)
				ASF_IDLE: if (take) begin
					code_q <= cmd.code;
					if ((cmd.code == CMD_SET_PW) ||
						((cmd.code == CMD_UNLOCK) && (tries_q != 3'h0))) begin
						st_q <= ASF_DATA;
					end else if ((cmd.code == CMD_SETFEAT) && (cmd.feat == SF_WC_DIS)) begin
						st_q <= ASF_FLUSH;
					end
				end
				ASF_DATA:  if (last) st_q <= ASF_IDLE;
				ASF_FLUSH: if (flush_ack) st_q <= ASF_IDLE;
				default:   st_q <= ASF_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sector word capture and compare
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst || take) begin
			widx_q <= 8'h00;
			miss_q <= 1'b0;
		end else if (word) begin
			widx_q <= widx_q + 8'h01;
			if ((widx_q >= PW_FIRST) && (widx_q <= PW_LAST) && (dw_data != pw_ref)) begin
				miss_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			id_master_q <= 1'b0;
			lvl_new_q   <= 1'b0;
		end else if (word && (widx_q == 8'h00)) begin
			id_master_q <= dw_data[CW_ID_BIT];
			lvl_new_q   <= dw_data[CW_LVL_BIT];
		end
	end

	// Password store survives reset
	always_ff @(posedge clk) begin
		if (word && (code_q == CMD_SET_PW) && (widx_q >= PW_FIRST) && (widx_q <= PW_LAST)) begin
			if (id_master_q) begin
				master_pw[pw_i] <= dw_data;
			end else begin
				user_pw[pw_i] <= dw_data;
			end
		end
	end

	// Security enable and level persist over reset; cleared from register
	always_ff @(posedge clk) begin
		if (last && (code_q == CMD_SET_PW) && !id_master_q) begin
			sec_en_q  <= 1'b1;
			lvl_max_q <= lvl_new_q;
		end else if (nv_clr) begin
			sec_en_q  <= 1'b0;
			lvl_max_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Lock state and attempt counter
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			locked_q <= sec_en_q;
			tries_q  <= UNLOCK_TRIES;
		end else begin
			if (ul_end && locked_q && !ul_bad) locked_q <= 1'b0;
			if (nv_clr) locked_q <= 1'b0;
			if (ul_dec) tries_q <= tries_q - 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Feature state
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst || (soft_rst && por_srst_q)) begin
			eight_q    <= 1'b0;
			wc_q       <= WC_DEF;
			rla_q      <= 1'b1;
			apm_en_q   <= 1'b0;
			apm_lvl_q  <= APM_MAX;
			cur_q      <= CUR_MAX;
			pio_q      <= 3'h0;
			no_iordy_q <= 1'b0;
			dma_q      <= ASF_DMA_NONE;
			dma_mode_q <= 3'h0;
			if (!nrst) por_srst_q <= 1'b1;
		end else if (take && (cmd.code == CMD_SETFEAT) && !sf_bad) begin
			case (cmd.feat)
				SF_8BIT_EN:  eight_q <= 1'b1;
				SF_8BIT_DIS: eight_q <= 1'b0;
				SF_WC_EN:    wc_q <= 1'b1;
				SF_WC_DIS:   wc_q <= 1'b0;
				SF_APM_EN: begin
					apm_en_q  <= 1'b1;
					apm_lvl_q <= cmd.scnt;
				end
				SF_APM_DIS:  apm_en_q <= 1'b0;
				SF_RLA_DIS:  rla_q <= 1'b0;
				SF_RLA_EN:   rla_q <= 1'b1;
				SF_POR_DIS:  por_srst_q <= 1'b0;
				SF_POR_EN:   por_srst_q <= 1'b1;
				SF_CUR_LIM:  cur_q <= cmd.scnt;
				SF_XFER: begin
					case (xtype)
						XT_PIO_DEF: begin
							pio_q      <= 3'h0;
							no_iordy_q <= (xmode == XM_NO_IORDY);
						end
						XT_PIO_FC: begin
							pio_q      <= xmode;
							no_iordy_q <= 1'b0;
						end
						XT_MDMA: begin
							dma_q      <= ASF_DMA_MW;
							dma_mode_q <= xmode;
						end
						XT_UDMA: begin
							dma_q      <= ASF_DMA_UL;
							dma_mode_q <= xmode;
						end
						default: pio_q <= pio_q;
					endcase
				end
				default: eight_q <= eight_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Completion and result
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			done <= 1'b0;
			res  <= '{status: STAT_DRDY, error: 8'h00, cyl_lo: 8'h00, cyl_hi: 8'h00};
		end else begin
			done <= 1'b0;
			if (take && !((cmd.code == CMD_SET_PW) ||
				((cmd.code == CMD_UNLOCK) && (tries_q != 3'h0)) ||
				((cmd.code == CMD_SETFEAT) && (cmd.feat == SF_WC_DIS)))) begin
				done <= 1'b1;
				if ((cmd.code == CMD_SETFEAT) && !sf_bad) begin
					res <= '{status: STAT_DRDY, error: 8'h00,
						cyl_lo: (cmd.feat == SF_CUR_LIM) ? CUR_MIN : 8'h00,
						cyl_hi: (cmd.feat == SF_CUR_LIM) ? CUR_MAX : 8'h00};
				end else begin
					res <= '{status: STAT_DRDY | STAT_ERR, error: ERR_ABRT,
						cyl_lo: 8'h00, cyl_hi: 8'h00};
				end
			end else if (last || ((st_q == ASF_FLUSH) && flush_ack)) begin
				done <= 1'b1;
				res  <= '{status: ul_bad ? (STAT_DRDY | STAT_ERR) : STAT_DRDY,
					error: ul_bad ? ERR_ABRT : 8'h00, cyl_lo: 8'h00, cyl_hi: 8'h00};
			end
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_noiordy_q <= 1'b0;
		end else if (reg_wr && (reg_addr == REG_CFG)) begin
			cfg_noiordy_q <= reg_wdata[CFG_NOIORDY];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CFG:  reg_rdata <= {15'h0000, cfg_noiordy_q};
				REG_SEC:  reg_rdata <= {10'h000, tries_q, lvl_max_q, sec_en_q, locked_q};
				REG_FEAT: reg_rdata <= {8'h00, apm_lvl_q[0], por_srst_q, apm_en_q,
					rla_q, wc_q, eight_q, iordy_en, no_iordy_q};
				REG_MODE: reg_rdata <= {cur_q[4:0], dma_q, dma_mode_q, 3'h0, pio_q};
				default:  reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_zero_tries_abort: assert property (
		take && (cmd.code == CMD_UNLOCK) && (tries_q == 3'h0)
		|=> done && (res.error == ERR_ABRT) && (st_q == ASF_IDLE))
		else $error("unlock with no tries left not aborted");
	a_mismatch_count: assert property (
		ul_dec |=> (tries_q == $past(tries_q) - 3'h1) && done && res.status[0])
		else $error("mismatch did not decrement counter");
	a_unlocked_count: assert property (
		ul_end && !locked_q |=> $stable(tries_q))
		else $error("counter moved while unlocked");
	a_bad_sub_abort: assert property (
		take && (cmd.code == CMD_SETFEAT) && sf_bad |=> done && (res.error == ERR_ABRT))
		else $error("bad subcommand not aborted");
	a_flush_first: assert property (
		flush_req && !flush_ack |=> !done)
		else $error("cache disable completed before flush");
	a_dma_exclusive: assert property (
		take && (cmd.code == CMD_SETFEAT) && (cmd.feat == SF_XFER) && !sf_bad
		&& (xtype == XT_UDMA) |=> (dma_q == ASF_DMA_UL))
		else $error("ultra DMA not selected exclusively");
	a_iordy_high_pio: assert property (
		take && (cmd.code == CMD_SETFEAT) && (cmd.feat == SF_XFER) && !sf_bad
		&& (xtype == XT_PIO_FC) && (xmode >= PIO_IORDY_MIN) |=> iordy_en)
		else $error("IORDY off at high PIO mode");
	a_eight_bit_ind: assert property (
		eight_q && data_reg_acc |-> !sixteen_bit_io_indicator)
		else $error("16-bit indicator in 8-bit mode");
	a_master_max_rej: assert property (
		ul_end && locked_q && id_master_q && lvl_max_q |=> locked_q && res.status[0])
		else $error("master unlock accepted at maximum level");
	a_cur_limit_ret: assert property (
		take && (cmd.code == CMD_SETFEAT) && (cmd.feat == SF_CUR_LIM)
		|=> (res.cyl_lo == CUR_MIN) && (res.cyl_hi == CUR_MAX))
		else $error("current limit range not returned");

	c_unlock_ok:  cover property (ul_end && locked_q && !ul_bad);
	c_set_user:   cover property (last && (code_q == CMD_SET_PW) && !id_master_q);
	c_flush_done: cover property ((st_q == ASF_FLUSH) && flush_ack);
endmodule : asf_core

// ---- asf_host.sv ----
// Host controller model: task file commands, data sectors, flush answers
module asf_host (
	// Clock
	input  wire logic         clk,
	// Command
	output asf_pkg::asf_cmd_t cmd,
	output logic              cmd_valid,
	input  wire logic         cmd_ready,
	// Sector words
	output logic              dw_valid,
	output logic [15:0]       dw_data,
	input  wire logic         dw_ready,
	// Flush
	input  wire logic         flush_req,
	output logic              flush_ack
);
	import asf_pkg::*;

	int flush_wait = 0;
	int fcnt       = 0;

	initial begin
		cmd       = '0;
		cmd_valid = 1'b0;
		dw_valid  = 1'b0;
		dw_data   = 16'h0000;
		flush_ack = 1'b0;
	end

	// Offer a command until the block takes it, then scramble the bus
	task automatic issue(input asf_cmd_t c);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd       <= c;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		cmd       <= ~c;
	endtask : issue

	// One full sector: control word, password words, filler
	task automatic send_sector(input logic [15:0] ctrl, input logic [7:0] pw);
		logic [15:0] w;
		for (int i = 0; i < 256; i++) begin
			w = (i == 0) ? ctrl : (i <= 16) ? {pw, 8'(i)} : 16'hA5A5 ^ 16'(i);
			dw_valid <= 1'b1;
			dw_data  <= w;
			do @(posedge clk); while (dw_ready !== 1'b1);
		end
		dw_valid <= 1'b0;
		dw_data  <= ~w;
	endtask : send_sector

	// Flush answered after a chosen wait, one-cycle pulse
	always @(posedge clk) begin
		if (flush_req === 1'b1 && flush_ack === 1'b0 && fcnt >= flush_wait) begin
			flush_ack <= 1'b1;
			fcnt      <= 0;
		end else begin
			flush_ack <= 1'b0;
			fcnt      <= (flush_req === 1'b1) ? fcnt + 1 : 0;
		end
	end
endmodule : asf_host

// ---- asf_core_bench.sv ----
// Testbench: security and set-features command block
module asf_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import asf_pkg::*;

	localparam logic [7:0] CUR_MN = 8'h01;
	localparam logic [7:0] CUR_MX = 8'h7D;
	localparam logic [7:0] OK     = STAT_DRDY;
	localparam logic [7:0] AB     = STAT_DRDY | STAT_ERR;

	logic clk, nrst, soft_rst, cmd_valid, cmd_ready, dw_valid, dw_ready, done;
	logic flush_req, flush_ack, data_reg_acc, sixteen, low_lanes, iordy_en;
	logic look_ahead_en, wcache_en, reg_wr, reg_rd;
	logic [15:0] dw_data, reg_wdata, reg_rdata;
	logic [3:0]  reg_addr;
	asf_cmd_t    cmd;
	asf_res_t    res;
	int          miscompares = 0;
	int          checked     = 0;
	int          lat;

	// Feature table: {feature, count, status}
	logic [23:0] ftab [0:21] = '{24'h010040, 24'h810040, 24'h020040, 24'h050140,
		24'h05FE40, 24'h050041, 24'h05FF41, 24'h850040, 24'h550040, 24'hAA0040,
		24'h660040, 24'hCC0040, 24'h690040, 24'h960040, 24'h970040, 24'h090040,
		24'h890040, 24'h0A0040, 24'h8A0040, 24'hBB0040, 24'h040041, 24'h830041};
	// Transfer modes: {count, status, mode register}
	logic [31:0] xtab [0:9] = '{32'h01400000, 32'h0C400004, 32'h0D410004,
		32'h22400284, 32'h46400584, 32'h21400244, 32'h10410244, 32'h47410244,
		32'h23410244, 32'h00400240};

	asf_core #(.CUR_MIN(CUR_MN), .CUR_MAX(CUR_MX)) uut (
		.clk(clk), .nrst(nrst), .soft_rst(soft_rst),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.dw_valid(dw_valid), .dw_data(dw_data), .dw_ready(dw_ready),
		.done(done), .res(res), .flush_req(flush_req), .flush_ack(flush_ack),
		.data_reg_acc(data_reg_acc), .sixteen_bit_io_indicator(sixteen),
		.low_lanes_only(low_lanes), .iordy_en(iordy_en),
		.look_ahead_en(look_ahead_en), .wcache_en(wcache_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	asf_host host (
		.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.dw_valid(dw_valid), .dw_data(dw_data), .dw_ready(dw_ready),
		.flush_req(flush_req), .flush_ack(flush_ack));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	endtask : reg_check

	task automatic do_cmd(input logic [7:0] code, feat, scnt, input logic [15:0] ctrl,
		input logic [7:0] pw, input bit sect, input logic [7:0] st, output int n);
		host.issue('{code, feat, scnt});
		if (sect)
			host.send_sector(ctrl, pw);
		n = 1;
		#1;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({15'h0, done}, 16'h0001);
		chk({8'h00, res.status}, {8'h00, st});
		chk({8'h00, res.error}, (st === AB) ? {8'h00, ERR_ABRT} : 16'h0000);
	endtask : do_cmd

	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
	endtask : do_reset

	task automatic pulse_soft(input logic exp);
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({15'h0, look_ahead_en}, {15'h0, exp});
	endtask : pulse_soft

	// ------------------------------------------------------------
	// Clock, watchdog, tests
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#(8 * 30000);
		miscompares++;
		summarize();
	end

	initial begin
		nrst         = 1'b0;
		soft_rst     = 1'b0;
		data_reg_acc = 1'b1;
		reg_addr     = 4'h0;
		reg_wdata    = 16'h0000;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		reg_check(REG_FEAT, 16'hFFFF, 16'h005A);
		reg_write(REG_CFG, 16'h0003);
		reg_write(REG_SEC, 16'hFFFF);
		reg_check(REG_SEC, 16'hFFFF, 16'h0028);
		reg_check(4'hC, 16'hFFFF, 16'h0000);
		for (int i = 0; i < 22; i++)
			do_cmd(CMD_SETFEAT, ftab[i][23:16], ftab[i][15:8], 0, 0, 0, ftab[i][7:0], lat);
		for (int i = 0; i < 10; i++) begin
			do_cmd(CMD_SETFEAT, SF_XFER, xtab[i][31:24], 0, 0, 0, xtab[i][23:16], lat);
			reg_check(REG_MODE, 16'h07C7, xtab[i][15:0]);
			if (i < 2)
				chk({15'h0, iordy_en}, 16'(i));
		end
		do_cmd(CMD_SETFEAT, SF_8BIT_EN, 0, 0, 0, 0, OK, lat);
		chk({14'h0, low_lanes, sixteen}, 16'h0002);
		do_cmd(CMD_SETFEAT, SF_8BIT_DIS, 0, 0, 0, 0, OK, lat);
		chk({14'h0, low_lanes, sixteen}, 16'h0001);
		do_cmd(CMD_SETFEAT, SF_RLA_DIS, 0, 0, 0, 0, OK, lat);
		pulse_soft(1'b1);
		do_cmd(CMD_SETFEAT, SF_POR_DIS, 0, 0, 0, 0, OK, lat);
		do_cmd(CMD_SETFEAT, SF_RLA_DIS, 0, 0, 0, 0, OK, lat);
		pulse_soft(1'b0);
		do_cmd(CMD_SETFEAT, SF_POR_EN, 0, 0, 0, 0, OK, lat);
		host.flush_wait = 6;
		do_cmd(CMD_SETFEAT, SF_WC_DIS, 0, 0, 0, 0, OK, lat);
		chk({15'h0, lat > 6}, 16'h0001);
		chk({15'h0, wcache_en}, 16'h0000);
		host.flush_wait = 0;
		do_cmd(CMD_SETFEAT, SF_WC_EN, 0, 0, 0, 0, OK, lat);
		chk({15'h0, wcache_en}, 16'h0001);
		do_cmd(CMD_SETFEAT, SF_WC_DIS, 0, 0, 0, 0, OK, lat);
		do_cmd(CMD_SETFEAT, SF_CUR_LIM, 8'h06, 0, 0, 0, OK, lat);
		chk({res.cyl_hi, res.cyl_lo}, {CUR_MX, CUR_MN});
		do_cmd(CMD_SET_PW, 0, 0, 16'h0001, 8'h11, 1, OK, lat);
		reg_check(REG_SEC, 16'h003F, 16'h0028);
		do_cmd(CMD_SET_PW, 0, 0, 16'h0000, 8'h22, 1, OK, lat);
		reg_check(REG_SEC, 16'h003F, 16'h002A);
		do_reset();
		reg_check(REG_SEC, 16'h003F, 16'h002B);
		do_cmd(CMD_UNLOCK, 0, 0, 16'h0000, 8'h33, 1, AB, lat);
		reg_check(REG_SEC, 16'h003F, 16'h0023);
		do_cmd(CMD_UNLOCK, 0, 0, 16'h0001, 8'h11, 1, OK, lat);
		reg_check(REG_SEC, 16'h003F, 16'h0022);
		do_cmd(CMD_UNLOCK, 0, 0, 16'h0000, 8'h33, 1, OK, lat);
		reg_check(REG_SEC, 16'h003F, 16'h0022);
		do_cmd(CMD_SET_PW, 0, 0, 16'h0100, 8'h22, 1, OK, lat);
		do_reset();
		reg_check(REG_SEC, 16'h003F, 16'h002F);
		do_cmd(CMD_UNLOCK, 0, 0, 16'h0001, 8'h11, 1, AB, lat);
		reg_check(REG_SEC, 16'h003F, 16'h002F);
		do_cmd(CMD_UNLOCK, 0, 0, 16'h0000, 8'h22, 1, OK, lat);
		reg_check(REG_SEC, 16'h003F, 16'h002E);
		do_reset();
		repeat (5) do_cmd(CMD_UNLOCK, 0, 0, 16'h0000, 8'h33, 1, AB, lat);
		reg_check(REG_SEC, 16'h003F, 16'h0007);
		do_cmd(CMD_UNLOCK, 0, 0, 16'h0000, 8'h22, 0, AB, lat);
		chk(16'(lat), 16'h0001);
		do_cmd(CMD_ERASE, 0, 0, 0, 0, 0, AB, lat);
		reg_write(REG_CFG, 16'h0002);
		summarize();
	end
endmodule : asf_core_bench
